// ===== design/dstream_fault_capture_pkg.sv
// constants for the data-stream fault capture register bank
// How it works
// - window read copies entry, returns zero
// - holding register returns copied entry, read-only
// - each window read advances entry pointer
// - capture registers frozen until fault address high word read
// - status updates only unlocked, on fault or parity error events
// - reset leaves captures and their locks alone
// - status bits 0-3: write, violation, read/write faults
// - bit 4 translation miss, bit 5 illegal address
// - bits 10:6 destination field, 16:11 opcode
// - fault address latched on each unlocked capture event
// - long format: base 63:33, address 42:13
// - short format: base 63:30, address 31:13
// - table base write-only, writable while locked
// - unlocked parity error loads bits, sets lock
// - writing one to lock releases, clears bits
// - locked later error sets second-error flag
// - dual-pipe same-cycle error sets no second-error flag
// - bits 2-5: data banks 0/1, tag banks 0/1
// - flush write drops every non-global entry except one filled in the same cycle
`default_nettype none
package dstream_fault_capture_pkg;
  localparam logic [7:0] OFF_WINDOW    = 8'h00;
  localparam logic [7:0] OFF_HOLD_LO   = 8'h04;
  localparam logic [7:0] OFF_HOLD_HI   = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0c;
  localparam logic [7:0] OFF_FADDR_LO  = 8'h10;
  localparam logic [7:0] OFF_FADDR_HI  = 8'h14;
  localparam logic [7:0] OFF_LOOKUP_LO = 8'h18;
  localparam logic [7:0] OFF_LOOKUP_HI = 8'h1c;
  localparam logic [7:0] OFF_BASE_LO   = 8'h20;
  localparam logic [7:0] OFF_BASE_HI   = 8'h24;
  localparam logic [7:0] OFF_PARITY    = 8'h28;
  localparam logic [7:0] OFF_FLUSH     = 8'h2c;
  localparam logic [7:0] OFF_MEMCTL    = 8'h30;
  localparam int FS_WR     = 0;
  localparam int FS_ACV    = 1;
  localparam int FS_FOR    = 2;
  localparam int FS_FOW    = 3;
  localparam int FS_MISS   = 4;
  localparam int FS_BADVA  = 5;
  localparam int FS_RA_LSB = 6;
  localparam int FS_OP_LSB = 11;
  localparam int PS_SEO    = 0;
  localparam int PS_LOCK   = 1;
  localparam int PS_BITS   = 2;
  localparam int MC_SHORT  = 1;
  localparam logic [31:0] RST_RDATA  = 32'h0000_0000;
  localparam logic [5:0]  RST_PTR    = 6'h00;
  localparam logic [5:0]  RST_MEMCTL = 6'h00;
endpackage : dstream_fault_capture_pkg
`default_nettype wire

// ===== design/dstream_fault_capture.sv
// data-stream fault capture, parity status and translation entry access over apb
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module dstream_fault_capture (
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [31:0]      prdata_o,
  input  wire logic        fault_i,
  input  wire logic        fault_write_i,
  input  wire logic        fault_acv_i,
  input  wire logic        fault_for_i,
  input  wire logic        fault_fow_i,
  input  wire logic        fault_miss_i,
  input  wire logic        fault_badva_i,
  input  wire logic [4:0]  fault_ra_i,
  input  wire logic [5:0]  fault_opcode_i,
  input  wire logic [63:0] fault_va_i,
  input  wire logic [3:0]  perr_pipe0_i,
  input  wire logic [3:0]  perr_pipe1_i,
  input  wire logic        fill_i,
  input  wire logic [5:0]  fill_idx_i,
  input  wire logic [63:0] fill_pte_i,
  input  wire logic        fill_global_i,
  output logic             capture_locked_o,
  output logic             parity_locked_o
);

  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_rdata;
  logic        nxt_hit;
  logic [63:0] pte_mem [64];
  logic [63:0] valid_ff;
  logic [63:0] global_ff;
  logic [5:0]  ptr_ff;
  logic [63:0] holding_ff;
  logic [16:0] status_ff;
  logic [63:0] faddr_ff;
  logic [63:0] lookup_ff;
  logic [63:0] base_ff;
  logic        cap_lock_ff;
  logic [5:0]  memctl_ff;
  logic [3:0]  perr_bits_ff;
  logic        perr_lock_ff;
  logic        seo_ff;
  logic        cap_out_ff;
  logic        par_out_ff;

  logic access;
  logic done;
  logic wr_done;
  logic rd_done;
  logic perr_any;
  logic perr_both;
  logic cap_event;
  logic cap_load;
  logic unlock_rd;
  logic clr_lock;
  logic clr_seo;

  assign access    = psel_i & penable_i;
  assign done      = access & pready_ff;
  assign wr_done   = done & pwrite_i;
  assign rd_done   = done & ~pwrite_i;
  assign perr_any  = (|perr_pipe0_i) | (|perr_pipe1_i);
  assign perr_both = (|perr_pipe0_i) & (|perr_pipe1_i);
  assign cap_event = fault_i | perr_any;
  assign cap_load  = cap_event & ~cap_lock_ff;
  assign unlock_rd = rd_done & (paddr_i == dstream_fault_capture_pkg::OFF_FADDR_HI);
  assign clr_lock  = wr_done & (paddr_i == dstream_fault_capture_pkg::OFF_PARITY)
                     & pwdata_i[dstream_fault_capture_pkg::PS_LOCK];
  assign clr_seo   = wr_done & (paddr_i == dstream_fault_capture_pkg::OFF_PARITY)
                     & pwdata_i[dstream_fault_capture_pkg::PS_SEO];

  // page table entry address from base and faulting address
  function automatic logic [63:0] form_lookup(input logic [63:0] base,
                                              input logic [63:0] va,
                                              input logic        short_fmt);
    logic [63:0] r;
    r = 64'h0;
    if (short_fmt) begin
      r = {base[63:30], 8'h00, va[31:13], 3'h0};
    end else begin
      r = {base[63:33], va[42:13], 3'h0};
    end
    return r;
  endfunction : form_lookup

  // apb: one wait state, answer registered
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= access & ~pready_ff;
    end
  end

  always_comb begin
    nxt_hit   = 1'b1;
    nxt_rdata = 32'h0;
    case (paddr_i)
      dstream_fault_capture_pkg::OFF_WINDOW:    nxt_rdata = 32'h0;
      dstream_fault_capture_pkg::OFF_HOLD_LO:   nxt_rdata = holding_ff[31:0];
      dstream_fault_capture_pkg::OFF_HOLD_HI:   nxt_rdata = holding_ff[63:32];
      dstream_fault_capture_pkg::OFF_STATUS:    nxt_rdata = {15'h0, status_ff};
      dstream_fault_capture_pkg::OFF_FADDR_LO:  nxt_rdata = faddr_ff[31:0];
      dstream_fault_capture_pkg::OFF_FADDR_HI:  nxt_rdata = faddr_ff[63:32];
      dstream_fault_capture_pkg::OFF_LOOKUP_LO: nxt_rdata = lookup_ff[31:0];
      dstream_fault_capture_pkg::OFF_LOOKUP_HI: nxt_rdata = lookup_ff[63:32];
      dstream_fault_capture_pkg::OFF_BASE_LO:   nxt_rdata = 32'h0;
      dstream_fault_capture_pkg::OFF_BASE_HI:   nxt_rdata = 32'h0;
      dstream_fault_capture_pkg::OFF_PARITY:    nxt_rdata = {26'h0, perr_bits_ff,
                                                             perr_lock_ff, seo_ff};
      dstream_fault_capture_pkg::OFF_FLUSH:     nxt_rdata = 32'h0;
      dstream_fault_capture_pkg::OFF_MEMCTL:    nxt_rdata = {26'h0, memctl_ff};
      default: begin
        nxt_hit   = 1'b0;
        nxt_rdata = 32'h0;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      prdata_ff  <= dstream_fault_capture_pkg::RST_RDATA;
      pslverr_ff <= 1'b0;
    end else if (access & ~pready_ff) begin
      prdata_ff  <= pwrite_i ? 32'h0 : nxt_rdata;
      pslverr_ff <= ~nxt_hit;
    end
  end

  // translation entries: fill port, flush and walk
  always_ff @(posedge mclk_i) begin
    if (fill_i) begin
      pte_mem[fill_idx_i] <= fill_pte_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      valid_ff  <= 64'h0;
      global_ff <= 64'h0;
    end else begin
      if (wr_done & (paddr_i == dstream_fault_capture_pkg::OFF_FLUSH)) begin
        valid_ff <= valid_ff & global_ff;
      end
      if (fill_i) begin
        valid_ff[fill_idx_i]  <= 1'b1;
        global_ff[fill_idx_i] <= fill_global_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ptr_ff     <= dstream_fault_capture_pkg::RST_PTR;
      holding_ff <= 64'h0;
    end else if (rd_done & (paddr_i == dstream_fault_capture_pkg::OFF_WINDOW)) begin
      holding_ff <= pte_mem[ptr_ff];
      ptr_ff     <= ptr_ff + 6'h01;
    end
  end

  // software writable control
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      memctl_ff <= dstream_fault_capture_pkg::RST_MEMCTL;
    end else if (wr_done & (paddr_i == dstream_fault_capture_pkg::OFF_MEMCTL)) begin
      memctl_ff <= pwdata_i[5:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (wr_done & (paddr_i == dstream_fault_capture_pkg::OFF_BASE_LO)) begin
      base_ff[31:0] <= pwdata_i;
    end
    if (wr_done & (paddr_i == dstream_fault_capture_pkg::OFF_BASE_HI)) begin
      base_ff[63:32] <= pwdata_i;
    end
  end

  // fault capture: no reset on purpose
  always_ff @(posedge mclk_i) begin
    if (cap_load) begin
      status_ff[dstream_fault_capture_pkg::FS_WR]    <= fault_write_i;
      status_ff[dstream_fault_capture_pkg::FS_ACV]   <= fault_acv_i | fault_badva_i;
      status_ff[dstream_fault_capture_pkg::FS_FOR]   <= fault_for_i;
      status_ff[dstream_fault_capture_pkg::FS_FOW]   <= fault_fow_i;
      status_ff[dstream_fault_capture_pkg::FS_MISS]  <= fault_miss_i;
      status_ff[dstream_fault_capture_pkg::FS_BADVA] <= fault_badva_i;
      status_ff[dstream_fault_capture_pkg::FS_RA_LSB +: 5] <= fault_ra_i;
      status_ff[dstream_fault_capture_pkg::FS_OP_LSB +: 6] <= fault_opcode_i;
      faddr_ff  <= fault_va_i;
      lookup_ff <= form_lookup(base_ff, fault_va_i,
                               memctl_ff[dstream_fault_capture_pkg::MC_SHORT]);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (cap_load) begin
      cap_lock_ff <= 1'b1;
    end else if (unlock_rd) begin
      cap_lock_ff <= 1'b0;
    end
  end

  // parity status: no reset on purpose
  always_ff @(posedge mclk_i) begin
    if (perr_any & ~perr_lock_ff) begin
      perr_bits_ff <= perr_pipe0_i | perr_pipe1_i;
      perr_lock_ff <= 1'b1;
    end else if (clr_lock) begin
      perr_bits_ff <= 4'h0;
      perr_lock_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (perr_any & perr_lock_ff) begin
      seo_ff <= 1'b1;
    end else if (clr_seo) begin
      seo_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cap_out_ff <= 1'b0;
      par_out_ff <= 1'b0;
    end else begin
      cap_out_ff <= cap_lock_ff === 1'b1;
      par_out_ff <= perr_lock_ff === 1'b1;
    end
  end

  assign pready_o         = pready_ff;
  assign pslverr_o        = pslverr_ff;
  assign prdata_o         = prdata_ff;
  assign capture_locked_o = cap_out_ff;
  assign parity_locked_o  = par_out_ff;

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  win_read_zero_a: assert property (
    (access & ~pready_ff & ~pwrite_i & (paddr_i == dstream_fault_capture_pkg::OFF_WINDOW))
    |=> (prdata_o == 32'h0))
    else $error("window read did not return zero");

  hold_copy_a: assert property (
    (rd_done & (paddr_i == dstream_fault_capture_pkg::OFF_WINDOW))
    |=> (holding_ff == $past(pte_mem[ptr_ff])))
    else $error("holding register did not take selected entry");

  ptr_walk_a: assert property (
    (rd_done & (paddr_i == dstream_fault_capture_pkg::OFF_WINDOW))
    |=> (ptr_ff == $past(ptr_ff) + 6'h01))
    else $error("entry pointer did not advance");

  lock_freeze_a: assert property (
    (cap_lock_ff & cap_event)
    |=> $stable(faddr_ff) && $stable(status_ff) && $stable(lookup_ff))
    else $error("capture registers changed while locked");

  va_latch_a: assert property (
    cap_load |=> (faddr_ff == $past(fault_va_i)) && cap_lock_ff)
    else $error("fault address not latched");

  miss_flag_a: assert property (
    cap_load |=> (status_ff[dstream_fault_capture_pkg::FS_MISS] == $past(fault_miss_i)))
    else $error("miss flag not captured");

  form_addr_a: assert property (
    (cap_load & memctl_ff[dstream_fault_capture_pkg::MC_SHORT])
    |=> (lookup_ff[21:3] == $past(fault_va_i[31:13]))
    && (lookup_ff[63:30] == $past(base_ff[63:30])))
    else $error("short format lookup address wrong");

  perr_load_a: assert property (
    (perr_any & ~perr_lock_ff)
    |=> perr_lock_ff && (perr_bits_ff == $past(perr_pipe0_i | perr_pipe1_i)))
    else $error("parity status not loaded");

  seo_set_a: assert property (
    (perr_any & perr_lock_ff) |=> seo_ff ##1 (seo_ff || $past(clr_seo)))
    else $error("second error flag not held");

  lock_clear_a: assert property (
    (clr_lock & perr_lock_ff & ~perr_any) |=> !perr_lock_ff && (perr_bits_ff == 4'h0))
    else $error("lock release did not clear bits");

  flush_ng_a: assert property (
    (wr_done & (paddr_i == dstream_fault_capture_pkg::OFF_FLUSH) & ~fill_i)
    |=> ((valid_ff & ~global_ff) == 64'h0)
    && ((valid_ff & global_ff) == $past(valid_ff & global_ff)))
    else $error("non-global entry survived flush");

  seo_dual_a: assert property (
    (perr_both & ~perr_lock_ff & ~seo_ff) |=> !seo_ff)
    else $error("dual pipe error set second error flag");

  seo_clear_a: assert property (
    (clr_seo & seo_ff & ~(perr_any & perr_lock_ff)) |=> !seo_ff)
    else $error("second error flag not cleared by write");

  hold_read_a: assert property (
    (access & ~pready_ff & ~pwrite_i & (paddr_i == dstream_fault_capture_pkg::OFF_HOLD_LO))
    |=> (prdata_o == $past(holding_ff[31:0])))
    else $error("holding register read wrong");

  status_bits_a: assert property (
    cap_load |=>
    (status_ff[dstream_fault_capture_pkg::FS_WR] == $past(fault_write_i))
    && (status_ff[dstream_fault_capture_pkg::FS_ACV] == $past(fault_acv_i | fault_badva_i))
    && (status_ff[dstream_fault_capture_pkg::FS_FOR] == $past(fault_for_i))
    && (status_ff[dstream_fault_capture_pkg::FS_FOW] == $past(fault_fow_i)))
    else $error("fault status access bits wrong");

  field_capture_a: assert property (
    cap_load |=>
    (status_ff[dstream_fault_capture_pkg::FS_RA_LSB +: 5] == $past(fault_ra_i))
    && (status_ff[dstream_fault_capture_pkg::FS_OP_LSB +: 6] == $past(fault_opcode_i)))
    else $error("instruction fields not captured");

  long_format_a: assert property (
    (cap_load & ~memctl_ff[dstream_fault_capture_pkg::MC_SHORT])
    |=> (lookup_ff[32:3] == $past(fault_va_i[42:13])))
    else $error("long format lookup address wrong");

  base_write_a: assert property (
    (wr_done & (paddr_i == dstream_fault_capture_pkg::OFF_BASE_LO))
    |=> (base_ff[31:0] == $past(pwdata_i)))
    else $error("table base write lost");

  unlock_read_a: assert property (
    (unlock_rd & cap_lock_ff) |=> !cap_lock_ff)
    else $error("fault address read did not unlock");

endmodule : dstream_fault_capture
`default_nettype wire

// ===== verification/dstream_fault_capture_tb.sv
// self-checking testbench for the data-stream fault capture register bank
`timescale 1ns/100ps
`default_nettype none
module dstream_fault_capture_tb;
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        pready_o, pslverr_o, capture_locked_o, parity_locked_o;
  logic [31:0] prdata_o;
  logic        fault_i = 1'b0, fault_write_i = 1'b0, fault_acv_i = 1'b0, fault_for_i = 1'b0;
  logic        fault_fow_i = 1'b0, fault_miss_i = 1'b0, fault_badva_i = 1'b0;
  logic [4:0]  fault_ra_i = 5'h0;
  logic [5:0]  fault_opcode_i = 6'h0;
  logic [63:0] fault_va_i = 64'h0;
  logic [3:0]  perr_pipe0_i = 4'h0, perr_pipe1_i = 4'h0;
  logic        fill_i = 1'b0, fill_global_i = 1'b0;
  logic [5:0]  fill_idx_i = 6'h0;
  logic [63:0] fill_pte_i = 64'h0;
  int          n_mismatch = 0;
  int          checked = 0;
  logic        err_q;

  dstream_fault_capture dstream_fault_capture_i (.mclk_i(mclk_i), .srst_i(srst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
    .fault_i(fault_i), .fault_write_i(fault_write_i), .fault_acv_i(fault_acv_i),
    .fault_for_i(fault_for_i), .fault_fow_i(fault_fow_i), .fault_miss_i(fault_miss_i),
    .fault_badva_i(fault_badva_i), .fault_ra_i(fault_ra_i), .fault_opcode_i(fault_opcode_i),
    .fault_va_i(fault_va_i), .perr_pipe0_i(perr_pipe0_i), .perr_pipe1_i(perr_pipe1_i),
    .fill_i(fill_i), .fill_idx_i(fill_idx_i), .fill_pte_i(fill_pte_i),
    .fill_global_i(fill_global_i), .capture_locked_o(capture_locked_o),
    .parity_locked_o(parity_locked_o));

  initial begin
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    q = prdata_o;
    err_q = pslverr_o;
    if (n >= 50) begin
      n_mismatch++;
      give_verdict();
    end else begin
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge mclk_i);
    end
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk({32'h0, q}, {32'h0, e});
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  // one-cycle event pulse, returns once the lock outputs have settled
  task automatic ev(input logic f, input logic [3:0] p0, input logic [3:0] p1);
    fault_i      <= f;
    perr_pipe0_i <= p0;
    perr_pipe1_i <= p1;
    @(posedge mclk_i);
    fault_i      <= 1'b0;
    perr_pipe0_i <= 4'h0;
    perr_pipe1_i <= 4'h0;
    repeat (2) @(posedge mclk_i);
  endtask : ev

  // one-cycle entry fill, then an idle cycle
  task automatic fill(input logic [5:0] i, input logic [63:0] p, input logic g);
    fill_i        <= 1'b1;
    fill_idx_i    <= i;
    fill_pte_i    <= p;
    fill_global_i <= g;
    @(posedge mclk_i);
    fill_i <= 1'b0;
    @(posedge mclk_i);
  endtask : fill

  task automatic t_window;
    fill(6'h00, 64'h0123_4567_89ab_cdef, 1'b0);
    fill(6'h01, 64'hfedc_ba98_7654_3210, 1'b1);
    rd(dstream_fault_capture_pkg::OFF_WINDOW, 32'h0);
    rd(dstream_fault_capture_pkg::OFF_HOLD_LO, 32'h89ab_cdef);
    wr(dstream_fault_capture_pkg::OFF_HOLD_LO, 32'hffff_ffff);
    rd(dstream_fault_capture_pkg::OFF_HOLD_HI, 32'h0123_4567);
    rd(dstream_fault_capture_pkg::OFF_HOLD_LO, 32'h89ab_cdef);
    rd(dstream_fault_capture_pkg::OFF_WINDOW, 32'h0);
    rd(dstream_fault_capture_pkg::OFF_HOLD_HI, 32'hfedc_ba98);
    rd(8'h40, 32'h0);
    chk({63'h0, err_q}, 64'h1);
  endtask : t_window

  task automatic t_fault;
    logic [63:0] b1, b2, va1, va2;
    b1 = 64'h8765_4321_0fed_cba9;
    b2 = 64'h1357_9bdf_2468_ace0;
    va1 = 64'h0000_0456_789a_bcd0;
    va2 = 64'h0000_0123_dead_e000;
    wr(dstream_fault_capture_pkg::OFF_BASE_LO, b1[31:0]);
    wr(dstream_fault_capture_pkg::OFF_BASE_HI, b1[63:32]);
    fault_write_i  <= 1'b1;
    fault_fow_i    <= 1'b1;
    fault_miss_i   <= 1'b1;
    fault_badva_i  <= 1'b1;
    fault_ra_i     <= 5'h15;
    fault_opcode_i <= 6'h2a;
    fault_va_i     <= va1;
    ev(1'b1, 4'h0, 4'h0);
    chk({63'h0, capture_locked_o}, 64'h1);
    rd(dstream_fault_capture_pkg::OFF_STATUS, {15'h0, 6'h2a, 5'h15, 6'h3b});
    rd(dstream_fault_capture_pkg::OFF_FADDR_LO, va1[31:0]);
    rd(dstream_fault_capture_pkg::OFF_LOOKUP_LO, {va1[41:13], 3'h0});
    rd(dstream_fault_capture_pkg::OFF_LOOKUP_HI, {b1[63:33], va1[42:42]});
    fault_write_i  <= 1'b0;
    fault_for_i    <= 1'b1;
    fault_acv_i    <= 1'b1;
    fault_badva_i  <= 1'b0;
    fault_ra_i     <= 5'h0a;
    fault_opcode_i <= 6'h11;
    fault_va_i     <= va2;
    ev(1'b1, 4'h0, 4'h0);
    rd(dstream_fault_capture_pkg::OFF_STATUS, {15'h0, 6'h2a, 5'h15, 6'h3b});
    srst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk({63'h0, capture_locked_o}, 64'h1);
    rd(dstream_fault_capture_pkg::OFF_STATUS, {15'h0, 6'h2a, 5'h15, 6'h3b});
    rd(dstream_fault_capture_pkg::OFF_FADDR_LO, va1[31:0]);
    wr(dstream_fault_capture_pkg::OFF_BASE_LO, b2[31:0]);
    wr(dstream_fault_capture_pkg::OFF_BASE_HI, b2[63:32]);
    rd(dstream_fault_capture_pkg::OFF_BASE_LO, 32'h0);
    wr(dstream_fault_capture_pkg::OFF_MEMCTL, 32'h2);
    rd(dstream_fault_capture_pkg::OFF_FADDR_HI, va1[63:32]);
    @(posedge mclk_i);
    chk({63'h0, capture_locked_o}, 64'h0);
    ev(1'b1, 4'h0, 4'h0);
    rd(dstream_fault_capture_pkg::OFF_STATUS, {15'h0, 6'h11, 5'h0a, 6'h1e});
    rd(dstream_fault_capture_pkg::OFF_LOOKUP_LO, {b2[31:30], 8'h0, va2[31:13], 3'h0});
    rd(dstream_fault_capture_pkg::OFF_LOOKUP_HI, b2[63:32]);
    rd(dstream_fault_capture_pkg::OFF_FADDR_HI, va2[63:32]);
  endtask : t_fault

  task automatic t_parity;
    ev(1'b0, 4'h5, 4'h0);
    chk({63'h0, parity_locked_o}, 64'h1);
    rd(dstream_fault_capture_pkg::OFF_PARITY, 32'h16);
    rd(dstream_fault_capture_pkg::OFF_FADDR_LO, 32'hdead_e000);
    ev(1'b0, 4'ha, 4'h0);
    rd(dstream_fault_capture_pkg::OFF_PARITY, 32'h17);
    wr(dstream_fault_capture_pkg::OFF_PARITY, 32'h2);
    rd(dstream_fault_capture_pkg::OFF_PARITY, 32'h01);
    chk({63'h0, parity_locked_o}, 64'h0);
    wr(dstream_fault_capture_pkg::OFF_PARITY, 32'h1);
    rd(dstream_fault_capture_pkg::OFF_PARITY, 32'h00);
    ev(1'b0, 4'h1, 4'h2);
    rd(dstream_fault_capture_pkg::OFF_PARITY, 32'h0e);
    wr(dstream_fault_capture_pkg::OFF_PARITY, 32'h3);
    ev(1'b0, 4'h8, 4'h4);
    rd(dstream_fault_capture_pkg::OFF_PARITY, 32'h32);
    fill(6'h02, 64'h0000_1111_2222_3333, 1'b0);
    fill(6'h03, 64'h4444_5555_6666_7777, 1'b1);
    wr(dstream_fault_capture_pkg::OFF_FLUSH, 32'h0);
  endtask : t_parity

  initial begin
    logic [31:0] q0;
    repeat (5) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    apb(1'b0, dstream_fault_capture_pkg::OFF_FADDR_HI, 32'h0, q0);
    ev(1'b1, 4'h0, 4'h0);
    wr(dstream_fault_capture_pkg::OFF_FADDR_HI, 32'hffff_ffff);
    rd(dstream_fault_capture_pkg::OFF_FADDR_HI, 32'h0);
    wr(dstream_fault_capture_pkg::OFF_PARITY, 32'h3);
    t_window();
    t_fault();
    t_parity();
    give_verdict();
  end
endmodule : dstream_fault_capture_tb
`default_nettype wire
